//--- core/dsp_mult_defs.vh
`ifndef DSP_MULT_DEFS_VH
`define DSP_MULT_DEFS_VH

// ----------------------------------------------------------------
// operand geometry
// ----------------------------------------------------------------
`define SUB_W        9
`define LANE_W       18
`define WIDE_W       36
`define LANES        4
`define SUBLANES     8
`define SET_COUNT    4
`define SET_SEL_W    2

// ----------------------------------------------------------------
// multiplier size modes
// ----------------------------------------------------------------
`define MODE_9X9     2'h0
`define MODE_18X18   2'h1
`define MODE_36X36   2'h2

// ----------------------------------------------------------------
// cascade chain and widths
// ----------------------------------------------------------------
`define CHAIN_MAX    224
`define SUB_PROD_W   18
`define LANE_PROD_W  36
`define WIDE_PROD_W  72
`define NARROW_TOP   35
`define NARROW_SRC   34

`endif

//--- core/operand_bank.v
`timescale 1ns/1ns
`include "dsp_mult_defs.vh"

module operand_bank #(
    parameter LANES  = `LANES,
    parameter LANE_W = `LANE_W
) (
    input  wire                          ref_clk,
    input  wire                          rst,
    input  wire                          advance,
    input  wire [1:0]                    mode,
    input  wire                          reg_en,
    input  wire                          shift_en,
    input  wire [LANES*`SET_SEL_W-1:0]   lane_sel,
    input  wire [`SET_COUNT-1:0]         clk_tick,
    input  wire [`SET_COUNT-1:0]         aclr,
    input  wire [`SET_COUNT-1:0]         ena,
    input  wire [LANES*LANE_W-1:0]       par_in,
    input  wire [LANE_W-1:0]             cascade_in,
    output wire [LANES*LANE_W-1:0]       operand,
    output wire [LANE_W-1:0]             cascade_out
);

    localparam W = LANES * LANE_W;

    reg  [W-1:0]     bank_reg;
    reg  [W-1:0]     bank_next;
    wire [W-1:0]     shifted;
    wire [W-1:0]     clr_mask;
    wire [LANES-1:0] lane_load;
    wire [LANES-1:0] lane_clr;
    wire             do_shift;

    // ----------------------------------------------------------------
    // per-lane choice of clock, clear and enable set
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < LANES; i = i + 1) begin : g_lane
            wire [`SET_SEL_W-1:0] sel = lane_sel[i*`SET_SEL_W +: `SET_SEL_W];
            assign lane_load[i] = advance & clk_tick[sel] & ena[sel]; // see (RQ10)
            assign lane_clr[i]  = aclr[sel]; // see (RQ10)
            assign clr_mask[i*LANE_W +: LANE_W] = {LANE_W{~lane_clr[i]}};
        end
    endgenerate

    // the wide mode has no cascaded input registers
    assign do_shift = shift_en & (mode != `MODE_36X36); // see (RQ15)

    // 9x9 chains step one sub-lane, wider ones a whole lane
    assign shifted = (mode == `MODE_9X9) ?
                     {bank_reg[W-`SUB_W-1:0], cascade_in[`SUB_W-1:0]} :
                     {bank_reg[W-LANE_W-1:0], cascade_in}; // see (RQ13)

    integer k;
    always @* begin
        bank_next = bank_reg;
        for (k = 0; k < LANES; k = k + 1) begin
            if (lane_clr[k]) begin
                bank_next[k*LANE_W +: LANE_W] = {LANE_W{1'b0}}; // see (RQ20)
            end else if (lane_load[k]) begin
                if (do_shift) begin
                    bank_next[k*LANE_W +: LANE_W] = shifted[k*LANE_W +: LANE_W]; // see (RQ12)
                end else begin
                    bank_next[k*LANE_W +: LANE_W] = par_in[k*LANE_W +: LANE_W]; // see (RQ11)
                end
            end
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            bank_reg <= {W{1'b0}};
        end else begin
            bank_reg <= bank_next;
        end
    end

    // clear acts at once through the mask, not only at the next edge
    assign operand = reg_en ? (bank_reg & clr_mask) : par_in; // see (RQ8) see (RQ20)

    assign cascade_out = (mode == `MODE_9X9) ?
                         {{(LANE_W-`SUB_W){1'b0}}, bank_reg[W-1:W-`SUB_W]} :
                         bank_reg[W-1:W-LANE_W]; // see (RQ12)

endmodule

//--- core/two_entry_buffer.v
`timescale 1ns/1ns
`include "dsp_mult_defs.vh"

module two_entry_buffer #(
    parameter W = 8
) (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);

    reg [W-1:0] head_reg;
    reg [W-1:0] tail_reg;
    reg [1:0]   count_reg;
    wire        push;
    wire        pop;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = head_reg;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge ref_clk) begin
        if (rst) begin
            head_reg  <= {W{1'b0}};
            tail_reg  <= {W{1'b0}};
            count_reg <= 2'h0;
        end else begin
            case (count_reg)
                2'h0: begin
                    if (push) begin
                        head_reg  <= in_data;
                        count_reg <= 2'h1;
                    end
                end
                2'h1: begin
                    if (push && pop) begin
                        head_reg <= in_data;
                    end else if (push) begin
                        tail_reg  <= in_data;
                        count_reg <= 2'h2;
                    end else if (pop) begin
                        count_reg <= 2'h0;
                    end
                end
                default: begin
                    if (pop) begin
                        head_reg  <= tail_reg;
                        count_reg <= 2'h1;
                    end
                end
            endcase
        end
    end

endmodule

//--- core/dsp_multiplier_block.v
// Behaviour
// (RQ1) eight 9x9, four 18x18 or one 36x36
// (RQ2) full 36x36 for matched fixed signedness
// (RQ3) fixed mixed sign: unsigned operand 35 bits
// (RQ4) dynamic versus fixed signed: dynamic 35 bits
// (RQ5) dynamic versus fixed unsigned: unsigned 35 bits
// (RQ6) two separate dynamic controls: 35 by 35
// (RQ7) one shared dynamic control: full 36x36
// (RQ8) optional input registers, array, pipeline register
// (RQ9) products optionally routed to in-block adder
// (RQ10) each operand set picks one of four sets
// (RQ11) parallel mode loads from routing, all sizes
// (RQ12) shift mode drives two cascade outputs
// (RQ13) cascade outputs feed the next stage
// (RQ14) chain may end anywhere, up to 224
// (RQ15) fabric builds shift registers in 36x36 mode
// (RQ16) one operand parallel while the other shifts
// (RQ17) sign controls unregistered or registered once
// (RQ18) sign high means signed; either signed, signed
// (RQ19) products keep full precision always
// (RQ20) selected clear zeroes operand registers at once; the mask zeroes operand at once, cascade_out only at the next edge
`timescale 1ns/1ns
`include "dsp_mult_defs.vh"

module dsp_multiplier_block #(
    parameter LANES     = `LANES,
    parameter LANE_W    = `LANE_W,
    parameter CHAIN_MAX = `CHAIN_MAX
) (
    input  wire                          ref_clk,
    input  wire                          rst,
    input  wire [1:0]                    mode,
    input  wire                          in_reg_en,
    input  wire                          pipe_en,
    input  wire                          sign_reg_en,
    input  wire                          shift_a_en,
    input  wire                          shift_b_en,
    input  wire                          route_adder,
    input  wire                          a_dynamic,
    input  wire                          b_dynamic,
    input  wire                          a_fixed_signed,
    input  wire                          b_fixed_signed,
    input  wire                          sign_shared,
    input  wire [LANES*`SET_SEL_W-1:0]   sel_a,
    input  wire [LANES*`SET_SEL_W-1:0]   sel_b,
    input  wire [`SET_COUNT-1:0]         clk_tick,
    input  wire [`SET_COUNT-1:0]         aclr,
    input  wire [`SET_COUNT-1:0]         ena,
    input  wire                          sign_a,
    input  wire                          sign_b,
    input  wire                          in_valid,
    output wire                          in_ready,
    input  wire [LANES*LANE_W-1:0]       data_a,
    input  wire [LANES*LANE_W-1:0]       data_b,
    input  wire [LANE_W-1:0]             cascade_in_a,
    input  wire [LANE_W-1:0]             cascade_in_b,
    output wire [LANE_W-1:0]             cascade_out_a,
    output wire [LANE_W-1:0]             cascade_out_b,
    output wire                          product_valid,
    input  wire                          product_ready,
    output wire                          adder_valid,
    input  wire                          adder_ready,
    output wire [LANES*2*LANE_W-1:0]     product,
    output wire                          product_signed,
    output wire                          narrow_a,
    output wire                          narrow_b
);

    localparam OP_W   = LANES * LANE_W;
    localparam PROD_W = LANES * 2 * LANE_W;
    localparam WORD_W = PROD_W + 1;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // in the wide mode none, one or both operands lose their top bit of range
    function narrow_of;
        input this_dyn;
        input this_signed;
        input other_dyn;
        input other_signed;
        input shared;
        begin
            if (this_dyn && other_dyn) begin
                narrow_of = ~shared; // see (RQ6) see (RQ7)
            end else if (this_dyn) begin
                narrow_of = other_signed; // see (RQ4) see (RQ5)
            end else if (other_dyn) begin
                narrow_of = ~this_signed; // see (RQ4) see (RQ5)
            end else begin
                narrow_of = ~this_signed & other_signed; // see (RQ2) see (RQ3)
            end
        end
    endfunction

    function [`WIDE_W-1:0] limit_wide;
        input [`WIDE_W-1:0] value;
        input               narrow;
        input               is_signed;
        begin
            limit_wide = value;
            if (narrow) begin
                limit_wide[`NARROW_TOP] = is_signed & value[`NARROW_SRC];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // flow control
    // ----------------------------------------------------------------
    wire             buf_in_ready;
    wire             buf_in_valid;
    wire             buf_out_valid;
    wire             buf_out_ready;
    wire [WORD_W-1:0] buf_in_data;
    wire [WORD_W-1:0] buf_out_data;
    wire             advance;
    wire             take;

    // a full buffer stalls every stage so no word is dropped
    assign advance  = buf_in_ready;
    assign in_ready = buf_in_ready;
    assign take     = advance & in_valid;

    // ----------------------------------------------------------------
    // operand registers
    // ----------------------------------------------------------------
    wire [OP_W-1:0] op_a;
    wire [OP_W-1:0] op_b;

    // each operand has its own shift enable, so a coefficient can sit still
    operand_bank #(
        .LANES  (LANES),
        .LANE_W (LANE_W)
    ) bank_a (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .advance     (take),
        .mode        (mode),
        .reg_en      (in_reg_en),
        .shift_en    (shift_a_en), // see (RQ16)
        .lane_sel    (sel_a),
        .clk_tick    (clk_tick),
        .aclr        (aclr),
        .ena         (ena),
        .par_in      (data_a),
        .cascade_in  (cascade_in_a),
        .operand     (op_a),
        .cascade_out (cascade_out_a)
    );

    operand_bank #(
        .LANES  (LANES),
        .LANE_W (LANE_W)
    ) bank_b (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .advance     (take),
        .mode        (mode),
        .reg_en      (in_reg_en),
        .shift_en    (shift_b_en), // see (RQ16)
        .lane_sel    (sel_b),
        .clk_tick    (clk_tick),
        .aclr        (aclr),
        .ena         (ena),
        .par_in      (data_b),
        .cascade_in  (cascade_in_b),
        .operand     (op_b),
        .cascade_out (cascade_out_b)
    );
    // chains longer than CHAIN_MAX stages are a fabric placement limit,
    // nothing here stops a chain from ending at this stage; see (RQ14)

    // ----------------------------------------------------------------
    // sign controls
    // ----------------------------------------------------------------
    reg  sign_a_reg;
    reg  sign_b_reg;
    reg  stage1_valid_reg;
    reg  narrow_a_reg;
    reg  narrow_b_reg;
    wire sign_a_now;
    wire sign_b_now;
    wire a_signed;
    wire b_signed;
    wire a_narrow;
    wire b_narrow;

    always @(posedge ref_clk) begin
        if (rst) begin
            sign_a_reg       <= 1'b0;
            sign_b_reg       <= 1'b0;
            stage1_valid_reg <= 1'b0;
            narrow_a_reg     <= 1'b0;
            narrow_b_reg     <= 1'b0;
        end else begin
            if (take) begin
                sign_a_reg <= sign_a;
                sign_b_reg <= sign_b;
            end
            if (advance) begin
                stage1_valid_reg <= in_valid;
            end
            narrow_a_reg <= a_narrow;
            narrow_b_reg <= b_narrow;
        end
    end

    // registered once so the sign lines up with registered operands
    assign sign_a_now = sign_reg_en ? sign_a_reg : sign_a; // see (RQ17)
    assign sign_b_now = sign_reg_en ? sign_b_reg : sign_b; // see (RQ17)

    // high means two's complement
    assign a_signed = a_dynamic ? sign_a_now : a_fixed_signed; // see (RQ18)
    // the shared control only applies when both operands are dynamic
    assign b_signed = b_dynamic ? ((a_dynamic & sign_shared) ? sign_a_now : sign_b_now) :
                      b_fixed_signed; // see (RQ7) see (RQ18)

    assign a_narrow = narrow_of(a_dynamic, a_fixed_signed, b_dynamic,
                                b_fixed_signed, sign_shared);
    assign b_narrow = narrow_of(b_dynamic, b_fixed_signed, a_dynamic,
                                a_fixed_signed, sign_shared);
    assign narrow_a = narrow_a_reg;
    assign narrow_b = narrow_b_reg;

    // ----------------------------------------------------------------
    // multiplier array
    // ----------------------------------------------------------------
    reg        [PROD_W-1:0]         prod_comb;
    reg signed [`SUB_W:0]           xa9;
    reg signed [`SUB_W:0]           xb9;
    reg signed [2*`SUB_W+1:0]       p9;
    reg signed [LANE_W:0]           xa18;
    reg signed [LANE_W:0]           xb18;
    reg signed [2*LANE_W+1:0]       p18;
    reg        [`WIDE_W-1:0]        wa;
    reg        [`WIDE_W-1:0]        wb;
    reg signed [`WIDE_W:0]          xa36;
    reg signed [`WIDE_W:0]          xb36;
    reg signed [2*`WIDE_W+1:0]      p36;
    integer                         n;

    // one extra sign bit per operand keeps every mix exact
    always @* begin
        prod_comb = {PROD_W{1'b0}};
        xa9  = {(`SUB_W+1){1'b0}};
        xb9  = {(`SUB_W+1){1'b0}};
        p9   = {(2*`SUB_W+2){1'b0}};
        xa18 = {(LANE_W+1){1'b0}};
        xb18 = {(LANE_W+1){1'b0}};
        p18  = {(2*LANE_W+2){1'b0}};
        wa   = {`WIDE_W{1'b0}};
        wb   = {`WIDE_W{1'b0}};
        xa36 = {(`WIDE_W+1){1'b0}};
        xb36 = {(`WIDE_W+1){1'b0}};
        p36  = {(2*`WIDE_W+2){1'b0}};
        case (mode)
            `MODE_9X9: begin
                for (n = 0; n < 2*LANES; n = n + 1) begin
                    xa9 = {a_signed & op_a[n*`SUB_W+`SUB_W-1], op_a[n*`SUB_W +: `SUB_W]};
                    xb9 = {b_signed & op_b[n*`SUB_W+`SUB_W-1], op_b[n*`SUB_W +: `SUB_W]};
                    p9  = xa9 * xb9;
                    prod_comb[n*`SUB_PROD_W +: `SUB_PROD_W] = p9[`SUB_PROD_W-1:0]; // see (RQ1) see (RQ19)
                end
            end
            `MODE_18X18: begin
                for (n = 0; n < LANES; n = n + 1) begin
                    xa18 = {a_signed & op_a[n*LANE_W+LANE_W-1], op_a[n*LANE_W +: LANE_W]};
                    xb18 = {b_signed & op_b[n*LANE_W+LANE_W-1], op_b[n*LANE_W +: LANE_W]};
                    p18  = xa18 * xb18;
                    prod_comb[n*`LANE_PROD_W +: `LANE_PROD_W] = p18[`LANE_PROD_W-1:0]; // see (RQ1) see (RQ19)
                end
            end
            `MODE_36X36: begin
                wa   = limit_wide(op_a[`WIDE_W-1:0], a_narrow, a_signed); // see (RQ3) see (RQ4)
                wb   = limit_wide(op_b[`WIDE_W-1:0], b_narrow, b_signed); // see (RQ5) see (RQ6)
                xa36 = {a_signed & wa[`WIDE_W-1], wa};
                xb36 = {b_signed & wb[`WIDE_W-1], wb};
                p36  = xa36 * xb36;
                prod_comb[`WIDE_PROD_W-1:0] = p36[`WIDE_PROD_W-1:0]; // see (RQ1) see (RQ19)
            end
            default: begin
                prod_comb = {PROD_W{1'b0}};
            end
        endcase
    end

    // ----------------------------------------------------------------
    // pipeline register after the array
    // ----------------------------------------------------------------
    reg  [WORD_W-1:0] pipe_reg;
    reg               pipe_valid_reg;
    wire              stage1_valid;
    wire [WORD_W-1:0] stage1_word;

    assign stage1_valid = in_reg_en ? stage1_valid_reg : in_valid;
    assign stage1_word  = {a_signed | b_signed, prod_comb}; // see (RQ18)

    always @(posedge ref_clk) begin
        if (rst) begin
            pipe_reg       <= {WORD_W{1'b0}};
            pipe_valid_reg <= 1'b0;
        end else if (advance) begin
            pipe_reg       <= stage1_word; // see (RQ8)
            pipe_valid_reg <= stage1_valid;
        end
    end

    assign buf_in_valid = pipe_en ? pipe_valid_reg : stage1_valid;
    assign buf_in_data  = pipe_en ? pipe_reg : stage1_word;

    // ----------------------------------------------------------------
    // output buffer and routing
    // ----------------------------------------------------------------
    two_entry_buffer #(
        .W (WORD_W)
    ) out_buf (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    // the same word goes either to the fabric or to the in-block adder
    assign product_valid  = buf_out_valid & ~route_adder; // see (RQ9)
    assign adder_valid    = buf_out_valid & route_adder; // see (RQ9)
    assign buf_out_ready  = route_adder ? adder_ready : product_ready;
    assign product        = buf_out_data[PROD_W-1:0];
    assign product_signed = buf_out_data[PROD_W];

endmodule

//--- verification/mult_monitor.sv
`timescale 1ns/1ns
`include "dsp_mult_defs.vh"
module mult_monitor #(
    parameter LANES  = `LANES,
    parameter LANE_W = `LANE_W
) (
    input wire                      ref_clk,
    input wire                      rst,
    input wire [1:0]                mode,
    input wire                      route_adder,
    input wire                      a_dynamic,
    input wire                      b_dynamic,
    input wire                      a_fixed_signed,
    input wire                      b_fixed_signed,
    input wire                      sign_shared,
    input wire                      product_valid,
    input wire                      product_ready,
    input wire                      adder_valid,
    input wire [LANES*2*LANE_W-1:0] product,
    input wire                      narrow_a,
    input wire                      narrow_b
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire m36 = mode == `MODE_36X36;
    wire fix = m36 && !a_dynamic && !b_dynamic;
    property p_route; (product_valid || adder_valid) |->
        adder_valid == route_adder && !(product_valid && adder_valid); endproperty
    a_route: assert property (p_route) else $error("misrouted");
    property p_hold; product_valid && !product_ready |=>
        product_valid && $stable(product); endproperty
    a_hold: assert property (p_hold) else $error("product lost");
    property p_match; fix && a_fixed_signed == b_fixed_signed |=> !narrow_a && !narrow_b;
    endproperty
    a_match: assert property (p_match) else $error("matched");
    property p_mixed; fix && a_fixed_signed != b_fixed_signed |=>
        narrow_a == !$past(a_fixed_signed) && narrow_b == !$past(b_fixed_signed); endproperty
    a_mixed: assert property (p_mixed) else $error("mixed");
    property p_dyn_a; m36 && a_dynamic && !b_dynamic |=>
        narrow_a == $past(b_fixed_signed) && narrow_b != $past(b_fixed_signed); endproperty
    a_dyn_a: assert property (p_dyn_a) else $error("dynamic a");
    property p_dyn_b; m36 && b_dynamic && !a_dynamic |=>
        narrow_b == $past(a_fixed_signed) && narrow_a != $past(a_fixed_signed); endproperty
    a_dyn_b: assert property (p_dyn_b) else $error("dynamic b");
    property p_two; m36 && a_dynamic && b_dynamic && !sign_shared |=> narrow_a && narrow_b;
    endproperty
    a_two: assert property (p_two) else $error("split");
    property p_shared; m36 && a_dynamic && b_dynamic && sign_shared |=>
        !narrow_a && !narrow_b; endproperty
    a_shared: assert property (p_shared) else $error("shared");
endmodule

bind dsp_multiplier_block mult_monitor #(.LANES(LANES), .LANE_W(LANE_W)) mult_monitor_inst (.*);

//--- verification/fabric_sink.sv
`timescale 1ns/1ns
module fabric_sink (
    input  wire ref_clk,
    input  wire stall,
    output reg  product_ready = 1'b0,
    output reg  adder_ready   = 1'b0
);
    // random refusals only when stalled
    always @(negedge ref_clk) begin
        product_ready <= !stall || $urandom % 3 != 0;
        adder_ready   <= !stall || $urandom % 3 != 0;
    end
endmodule

//--- verification/test_dsp_multiplier_block.sv
`timescale 1ns/1ns
`include "dsp_mult_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module test_dsp_multiplier_block;
    reg          ref_clk = 0, rst = 1, in_valid = 0, stall = 0, acc = 0;
    reg          in_reg_en = 0, pipe_en = 0, shift_a_en = 0, route_adder = 0, sign_a = 0;
    reg          a_dynamic = 0, b_dynamic = 0, a_fixed_signed = 0, b_fixed_signed = 0;
    reg          sign_shared = 0, sign_b = 0;
    reg  [1:0]   mode = 0;
    reg  [7:0]   sel_a = 0, sel_b = 0;
    reg  [3:0]   aclr = 0, ena = 4'hF;
    reg  [71:0]  data_a = 0, data_b = 0, sh = 0;
    reg  [17:0]  cascade_in_a = 0, exp_cas = 0;
    reg  [144:0] exp_q[$];
    int          miscompares = 0, total_checks = 0, cycles = 0, ph, k, m;
    wire         in_ready, product_valid, adder_valid, product_ready, adder_ready;
    wire         product_signed, narrow_a, narrow_b;
    wire [17:0]  cascade_out_a;
    wire [143:0] product;

    function automatic [143:0] calc(input [1:0] m, input [71:0] a, b, input sa, sb, na, nb);
        reg [143:0] r, pa, pb, mk;
        integer     i, w;
        r = 0;
        w = m == 0 ? 9 : m == 1 ? 18 : 36;
        if (na) a[35] = sa & a[34];
        if (nb) b[35] = sb & b[34];
        mk = (144'h1 << w) - 1;
        for (i = 0; i < (m == 0 ? 8 : m == 1 ? 4 : m == 2 ? 1 : 0); i++) begin
            pa = (a >> i * w) & mk;
            pb = (b >> i * w) & mk;
            if (sa && pa[w-1]) pa = pa | ~mk;
            if (sb && pb[w-1]) pb = pb | ~mk;
            r = r | (((pa * pb) & ((144'h1 << 2 * w) - 1)) << 2 * i * w);
        end
        calc = r;
    endfunction
    function automatic narrow(input ad, bd, afs, bfs, shr);
        narrow = ad && bd ? !shr : ad ? bfs : bd ? !afs : afs != bfs && !afs;
    endfunction
    function automatic [71:0] rnd();
        rnd = {8'($urandom), $urandom, $urandom};
    endfunction
    wire na = mode == 2 && narrow(a_dynamic, b_dynamic, a_fixed_signed, b_fixed_signed,
                                  sign_shared);
    wire nb = mode == 2 && narrow(b_dynamic, a_dynamic, b_fixed_signed, a_fixed_signed,
                                  sign_shared);

    dsp_multiplier_block dsp_multiplier_block_inst (.*, .sign_reg_en(in_reg_en),
        .shift_b_en(1'b0), .clk_tick(4'hF), .cascade_in_b(18'h0), .cascade_out_b());
    fabric_sink fabric_sink_inst (.*);

    initial forever #50 ref_clk = ~ref_clk;

    // pop before push
    always @(posedge ref_clk) begin : watch
        reg [71:0]  a, b;
        reg [144:0] e;
        reg         sa, sb;
        if (!rst && ((product_valid && product_ready) || (adder_valid && adder_ready))) begin
            e = exp_q.size() ? exp_q.pop_front() : 145'h0;
            `CHK(product_signed, e[144])
            `CHK(product, e[143:0])
        end
        if (!rst && in_valid && in_ready) begin
            acc = 1;
            a = data_a;
            b = data_b;
            sa = a_dynamic ? sign_a : a_fixed_signed;
            sb = b_dynamic ? (a_dynamic && sign_shared ? sign_a : sign_b) : b_fixed_signed;
            if (shift_a_en) begin
                sh = mode ? {sh[53:0], cascade_in_a} : {sh[62:0], cascade_in_a[8:0]};
                a = sh;
                exp_cas = mode ? sh[71:54] : {9'h0, sh[71:63]};
            end
            for (int i = 0; i < 4; i++) if (in_reg_en && aclr[0] && mode == 1) begin
                if (sel_a[2*i+:2] == 0) a[18*i+:18] = 0;
                if (sel_b[2*i+:2] == 0) b[18*i+:18] = 0;
            end
            exp_q.push_back({sa | sb, calc(mode, a, b, sa, sb, na, nb)});
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict;
        end
    end

    task send(input [71:0] a, input [71:0] b);
        begin
            data_a = a;
            data_b = b;
            {sign_a, sign_b} = 2'($urandom);
            in_valid = 1;
            acc = 0;
            while (!acc) @(negedge ref_clk);
            if ($urandom % 4 == 0) begin
                in_valid = 0;
                @(negedge ref_clk);
            end
        end
    endtask
    task drain;
        begin
            in_valid = 0;
            for (int t = 0; t < 300 && exp_q.size() != 0; t++) @(negedge ref_clk);
            `CHK(exp_q.size(), 0)
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    initial begin
        void'($urandom(32'h0DFD));
        repeat (16) @(negedge ref_clk);
        rst = 0;
        // ---
        // parallel words
        // ---
        for (ph = 0; ph < 24; ph++) begin
            mode = 2'(ph % 4);
            {in_reg_en, pipe_en, route_adder, stall} = 4'($urandom);
            {a_dynamic, b_dynamic, a_fixed_signed, b_fixed_signed, sign_shared} =
                mode == 2 ? 5'(32'h0C444B19 >> 5 * (ph / 4)) : 5'($urandom);
            {sel_a, sel_b} = 16'($urandom);
            aclr = {3'h0, mode == 1 && $urandom % 2};
            repeat (2) @(negedge ref_clk);
            for (k = 0; k < 30; k++)
                send(k % 5 == 0 ? {72{1'b1}} : k % 5 == 1 ? {8{9'h100}} : rnd(),
                     k % 7 == 0 ? {8{9'h100}} : rnd());
            drain;
        end
        // ---
        // clear, then cascade chain
        // ---
        for (m = 0; m < 2; m++) begin
            mode = 2'(m);
            {in_reg_en, shift_a_en, aclr, sel_a, stall} = {1'b1, 1'b0, 4'h0, 8'h0, 1'b0};
            send({72{1'b1}}, rnd());
            drain;
            `CHK(cascade_out_a, m ? 18'h3FFFF : 18'h001FF)
            {ena, aclr} = {4'h0, 4'hF};
            @(negedge ref_clk);
            `CHK(cascade_out_a, 18'h0)
            {ena, aclr, shift_a_en, sh, stall} = {4'hF, 4'h0, 1'b1, 72'h0, 1'b1};
            for (k = 0; k < 12; k++) begin
                cascade_in_a = 18'($urandom);
                send(rnd(), rnd());
                `CHK(cascade_out_a, exp_cas)
            end
            drain;
        end
        print_verdict;
    end
endmodule
